/* design/tpsd_pkg.sv */
// Constants for the tape path sensor diagnostics block.
// Assumes a 250 MHz system clock and a classic Wishbone slave port.
`default_nettype none

package tpsd_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_SENSE    = 8'h08;
    localparam logic [7:0] OFS_VALUE    = 8'h0c;
    localparam logic [7:0] OFS_FLIGHT   = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h1c;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int         MODE_W         = 3;
    localparam logic [2:0] MODE_OFF       = 3'h0;
    localparam logic [2:0] MODE_SENSOR    = 3'h1;
    localparam logic [2:0] MODE_RING      = 3'h2;
    localparam logic [2:0] MODE_ARM_POS   = 3'h3;
    localparam logic [2:0] MODE_ARM_RESP  = 3'h4;
    localparam logic [2:0] MODE_RST       = 3'h0;

    localparam int         ST_STATE_LSB   = 0;
    localparam int         ST_RING_ABSENT = 4;
    localparam int         ST_RING_PRES   = 5;
    localparam int         ST_FLIGHT_OK   = 6;
    localparam int         ST_LEGEND      = 7;

    // Interrupt events.
    localparam int         IRQ_W          = 4;
    localparam int         IRQ_TAPE_READY = 0;
    localparam int         IRQ_RING_CHECK = 1;
    localparam int         IRQ_FLIGHT     = 2;
    localparam int         IRQ_LEGEND     = 3;
    localparam logic [3:0] IRQ_EN_RST     = 4'h0;

    localparam int         VAL_W          = 10;
    localparam logic [9:0] VAL_MAX        = 10'h3e7;
    localparam logic [9:0] FLIGHT_LO_MS   = 10'h014;
    localparam logic [9:0] FLIGHT_HI_MS   = 10'h01e;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 4;
    localparam int HIGH_DRIVE_MS   = 1000;
    localparam int MS_NS           = 1000000;
    localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
    localparam int HIGH_DRIVE_CYC  = HIGH_DRIVE_MS * MS_CYCLES;
    localparam int TIMER_W         = 28;

endpackage : tpsd_pkg

`default_nettype wire

/* design/tpsd_sync.sv */
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; multi-bit words may skew by a cycle.
`default_nettype none

module tpsd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule : tpsd_sync

`default_nettype wire

/* design/tpsd_top.sv */
// Tape path sensor diagnostics: sensor display, solenoid tests, ring and arm tests.
// Assumes pins are asynchronous, tape motion logic is on clk_i.
//
// Operation
// RULE1 - Entering sensor or ring test: unload or rewind
// RULE2 - Sensor test shows one letter per asserted sensor
// RULE3 - Tens hub, units door, enter fan
// RULE4 - Solenoid high supply one second, then hold
// RULE5 - Write permit lamp follows ring flag
// RULE6 - Arm indication only between rest and far
// RULE7 - Ring test: absent then present on tens
// RULE8 - Arm test shows position value and legend
// RULE9 - Legend off leaving limit, on at far
// RULE10 - Time arm flight between limit flags
// RULE11 - Flight shown in ms, 20-30 acceptable
// RULE12 - De-energise outputs when action or test ends
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`default_nettype none

module tpsd_top #(
    parameter int MS_CYCLES      = tpsd_pkg::MS_CYCLES,
    parameter int HIGH_DRIVE_CYC = tpsd_pkg::HIGH_DRIVE_CYC,
    parameter int POS_W          = 10
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  irq_o,
    input  wire logic             tens_btn_i,
    input  wire logic             units_btn_i,
    input  wire logic             enter_btn_i,
    input  wire logic             chute_clear_i,
    input  wire logic             reel_flag_i,
    input  wire logic             bot_marker_i,
    input  wire logic             eot_marker_i,
    input  wire logic             ring_flag_i,
    input  wire logic             arm_rest_flag_i,
    input  wire logic             arm_far_flag_i,
    input  wire logic [POS_W-1:0] arm_pos_i,
    input  wire logic             tape_done_i,
    output logic                  unload_req_o,
    output logic                  rewind_req_o,
    output logic      [5:0]       display_letters_o,
    output logic      [9:0]       display_value_o,
    output logic                  limit_legend_o,
    output logic                  write_permit_lamp_o,
    output logic                  hub_solenoid_o,
    output logic                  door_solenoid_o,
    output logic                  hub_high_supply_o,
    output logic                  door_high_supply_o,
    output logic                  fan_o
);

    typedef enum logic [3:0] {
        S_IDLE, S_PREP, S_PREP_WAIT, S_SENSOR, S_RING_OUT, S_RING_IN, S_RING_DONE,
        S_ARM_POS, S_RESP_ARM, S_RESP_FLY, S_RESP_DONE
    } tpsd_state_t;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [9:0]       pins_s;
    logic [POS_W-1:0] pos_s;

    tpsd_sync #(.W(10)) u_sync_pins (.clk_i(clk_i), .rst_i(rst_i), .q_o(pins_s),
        .d_i({arm_far_flag_i, arm_rest_flag_i, ring_flag_i, eot_marker_i, bot_marker_i,
              reel_flag_i, chute_clear_i, enter_btn_i, units_btn_i, tens_btn_i}));
    tpsd_sync #(.W(POS_W)) u_sync_pos (.clk_i(clk_i), .rst_i(rst_i), .d_i(arm_pos_i),
        .q_o(pos_s));

    logic tens_s, units_s, enter_s, ring_s, rest_s, far_s, tens_prev_q, tens_press;
    logic [6:0] sensors;
    assign {enter_s, units_s, tens_s} = pins_s[2:0];
    assign {far_s, rest_s, ring_s}    = pins_s[9:7];
    // RULE6 arm between limits.
    assign sensors = {1'b0, ~rest_s & ~far_s, pins_s[7:3]};
    assign tens_press = tens_s & ~tens_prev_q;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
        reg_hit = (adr[7:2] == ofs[7:2]);
    endfunction : reg_hit

    logic        req, wr, mode_wr;
    logic [2:0]  mode_q;
    logic [3:0]  irq_stat_q, irq_en_q, irq_set, irq_clr;
    tpsd_state_t state_q;
    logic        ring_absent_ok_q, ring_present_ok_q, ring_seen_q, flight_ok_q;
    logic [9:0]  flight_q, value_d;
    logic [5:0]  letters_d;

    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr      = req & wb_we_i & wb_sel_i[0];
    assign mode_wr = wr & reg_hit(wb_adr_i, tpsd_pkg::OFS_CTRL);
    assign irq_clr = (wr & reg_hit(wb_adr_i, tpsd_pkg::OFS_IRQ_CLR)) ? wb_dat_i[3:0] : 4'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            mode_q   <= tpsd_pkg::MODE_RST;
            irq_en_q <= tpsd_pkg::IRQ_EN_RST;
        end else begin
            wb_ack_o <= req;
            if (mode_wr) begin
                mode_q <= wb_dat_i[2:0];
            end
            if (wr && reg_hit(wb_adr_i, tpsd_pkg::OFS_IRQ_EN)) begin
                irq_en_q <= wb_dat_i[3:0];
            end
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                if (reg_hit(wb_adr_i, tpsd_pkg::OFS_CTRL)) begin
                    wb_dat_o[2:0] <= mode_q;
                end else if (reg_hit(wb_adr_i, tpsd_pkg::OFS_STATUS)) begin
                    wb_dat_o[3:0] <= state_q;
                    wb_dat_o[tpsd_pkg::ST_RING_ABSENT] <= ring_absent_ok_q;
                    wb_dat_o[tpsd_pkg::ST_RING_PRES] <= ring_present_ok_q;
                    wb_dat_o[tpsd_pkg::ST_FLIGHT_OK] <= flight_ok_q;
                    wb_dat_o[tpsd_pkg::ST_LEGEND] <= limit_legend_o;
                end else if (reg_hit(wb_adr_i, tpsd_pkg::OFS_SENSE)) begin
                    wb_dat_o[6:0] <= sensors;
                end else if (reg_hit(wb_adr_i, tpsd_pkg::OFS_VALUE)) begin
                    wb_dat_o[9:0] <= display_value_o;
                end else if (reg_hit(wb_adr_i, tpsd_pkg::OFS_FLIGHT)) begin
                    wb_dat_o[9:0] <= flight_q;
                end else if (reg_hit(wb_adr_i, tpsd_pkg::OFS_IRQ_STAT)) begin
                    wb_dat_o[3:0] <= irq_stat_q;
                end else if (reg_hit(wb_adr_i, tpsd_pkg::OFS_IRQ_EN)) begin
                    wb_dat_o[3:0] <= irq_en_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // A set in the same cycle as its clear wins, so no event is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end
    assign irq_o = |(irq_stat_q & irq_en_q);

    // ------------------------------------------------------------
    // Test sequencer
    // ------------------------------------------------------------
    logic [tpsd_pkg::TIMER_W-1:0] ms_div_q;
    logic [9:0]                   ms_cnt_q;
    logic                         ms_tick;
    assign ms_tick = (ms_div_q == tpsd_pkg::TIMER_W'(MS_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q           <= S_IDLE;
            unload_req_o      <= 1'b0;
            rewind_req_o      <= 1'b0;
            ring_absent_ok_q  <= 1'b0;
            ring_present_ok_q <= 1'b0;
            ring_seen_q       <= 1'b0;
            flight_ok_q       <= 1'b0;
            flight_q          <= 10'h000;
            ms_div_q          <= '0;
            ms_cnt_q          <= 10'h000;
            tens_prev_q       <= 1'b0;
        end else begin
            tens_prev_q  <= tens_s;
            unload_req_o <= 1'b0;
            rewind_req_o <= 1'b0;
            ring_seen_q  <= ring_seen_q | ring_s;
            if (mode_wr) begin
                case (wb_dat_i[2:0])
                    tpsd_pkg::MODE_SENSOR, tpsd_pkg::MODE_RING: state_q <= S_PREP;
                    tpsd_pkg::MODE_ARM_POS:  state_q <= S_ARM_POS;
                    tpsd_pkg::MODE_ARM_RESP: state_q <= S_RESP_ARM;
                    default:                 state_q <= S_IDLE;
                endcase
            end else begin
                case (state_q)
                    // RULE1 unload or rewind.
                    S_PREP: begin
                        unload_req_o <= pins_s[5];
                        rewind_req_o <= ~pins_s[5];
                        state_q      <= S_PREP_WAIT;
                    end
                    S_PREP_WAIT: begin
                        if (tape_done_i) begin
                            ring_seen_q       <= 1'b0;
                            ring_absent_ok_q  <= 1'b0;
                            ring_present_ok_q <= 1'b0;
                            state_q <= (mode_q == tpsd_pkg::MODE_RING) ? S_RING_OUT : S_SENSOR;
                        end
                    end
                    // RULE7 ring absent check.
                    S_RING_OUT: begin
                        if (tens_press) begin
                            ring_absent_ok_q <= ~(ring_seen_q | ring_s);
                            ring_seen_q      <= 1'b0;
                            state_q          <= S_RING_IN;
                        end
                    end
                    // RULE7 ring present check.
                    S_RING_IN: begin
                        if (tens_press) begin
                            ring_present_ok_q <= ring_seen_q | ring_s;
                            state_q           <= S_RING_DONE;
                        end
                    end
                    // RULE10 wait for far flag set.
                    S_RESP_ARM: begin
                        ms_div_q <= '0;
                        ms_cnt_q <= 10'h000;
                        if (far_s) state_q <= S_RESP_FLY;
                    end
                    // RULE10 time flight to rest.
                    S_RESP_FLY: begin
                        ms_div_q <= ms_tick ? '0 : ms_div_q + 1'b1;
                        if (ms_tick && ms_cnt_q != tpsd_pkg::VAL_MAX) begin
                            ms_cnt_q <= ms_cnt_q + 10'h001;
                        end
                        if (far_s) begin
                            ms_div_q <= '0;
                            ms_cnt_q <= 10'h000;
                        end else if (rest_s) begin
                            flight_q <= ms_cnt_q;
                            // RULE11 acceptable window.
                            flight_ok_q <= (ms_cnt_q >= tpsd_pkg::FLIGHT_LO_MS) &&
                                           (ms_cnt_q <= tpsd_pkg::FLIGHT_HI_MS);
                            state_q <= S_RESP_DONE;
                        end
                    end
                    S_RESP_DONE: if (far_s) state_q <= S_RESP_ARM;
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        irq_set = 4'h0;
        irq_set[tpsd_pkg::IRQ_TAPE_READY] = (state_q == S_PREP_WAIT) & tape_done_i & ~mode_wr;
        irq_set[tpsd_pkg::IRQ_RING_CHECK] = (state_q == S_RING_IN) & tens_press & ~mode_wr;
        irq_set[tpsd_pkg::IRQ_FLIGHT] = (state_q == S_RESP_FLY) & ~far_s & rest_s & ~mode_wr;
        irq_set[tpsd_pkg::IRQ_LEGEND] = (state_q == S_ARM_POS) &
                                        (limit_legend_o != (rest_s | far_s));
    end

    // ------------------------------------------------------------
    // Display and lamp
    // ------------------------------------------------------------
    always_comb begin
        letters_d = 6'h00;
        value_d   = 10'h000;
        case (state_q)
            // RULE2 one letter per sensor.
            S_SENSOR: letters_d = sensors[5:0];
            // RULE8 position value.
            S_ARM_POS: value_d = (pos_s > POS_W'(tpsd_pkg::VAL_MAX)) ?
                                 tpsd_pkg::VAL_MAX : 10'(pos_s);
            // RULE11 flight in ms.
            S_RESP_FLY, S_RESP_DONE: value_d = (state_q == S_RESP_DONE) ? flight_q : ms_cnt_q;
            default: value_d = 10'h000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            display_letters_o   <= 6'h00;
            display_value_o     <= 10'h000;
            limit_legend_o      <= 1'b0;
            write_permit_lamp_o <= 1'b0;
        end else begin
            display_letters_o   <= letters_d;
            display_value_o     <= value_d;
            // RULE9 legend at either limit.
            limit_legend_o      <= (state_q == S_ARM_POS) & (rest_s | far_s);
            // RULE5 lamp follows flag.
            write_permit_lamp_o <= ring_s;
        end
    end

    // ------------------------------------------------------------
    // Solenoids and fan
    // ------------------------------------------------------------
    // Drives stay on only while the button is held inside the sensor test.
    logic [1:0] sol_on, sol_high;
    // RULE3 button to actuator.
    assign sol_on = (state_q == S_SENSOR) ? {units_s, tens_s} : 2'b00;

    for (genvar g = 0; g < 2; g++) begin : g_sol
        logic [tpsd_pkg::TIMER_W-1:0] hold_q;
        // RULE4 high supply one second.
        always_ff @(posedge clk_i) begin
            if (rst_i || !sol_on[g]) begin
                hold_q <= '0;
            end else if (hold_q != tpsd_pkg::TIMER_W'(HIGH_DRIVE_CYC)) begin
                hold_q <= hold_q + 1'b1;
            end
        end
        assign sol_high[g] = sol_on[g] & (hold_q != tpsd_pkg::TIMER_W'(HIGH_DRIVE_CYC));
    end

    // RULE12 de-energise on exit.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hub_solenoid_o     <= 1'b0;
            door_solenoid_o    <= 1'b0;
            hub_high_supply_o  <= 1'b0;
            door_high_supply_o <= 1'b0;
            fan_o              <= 1'b0;
        end else begin
            hub_solenoid_o     <= sol_on[0];
            door_solenoid_o    <= sol_on[1];
            hub_high_supply_o  <= sol_high[0];
            door_high_supply_o <= sol_high[1];
            fan_o              <= (state_q == S_SENSOR) & enter_s;
        end
    end

endmodule : tpsd_top

`default_nettype wire

/* test/tpsd_properties.sv */
// Port checks for the tape path diagnostics block.
// Assumes a bind into tpsd_top and a synchronous reset.
`default_nettype none

module tpsd_properties #(
    parameter int MS_CYCLES      = 10,
    parameter int HIGH_DRIVE_CYC = 50,
    parameter int POS_W          = 10
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       enter_btn_i,
    input wire logic       units_btn_i,
    input wire logic       bot_marker_i,
    input wire logic       ring_flag_i,
    input wire logic       arm_rest_flag_i,
    input wire logic       arm_far_flag_i,
    input wire logic       unload_req_o,
    input wire logic       rewind_req_o,
    input wire logic [5:0] display_letters_o,
    input wire logic [9:0] display_value_o,
    input wire logic       limit_legend_o,
    input wire logic       write_permit_lamp_o,
    input wire logic       hub_solenoid_o,
    input wire logic       door_solenoid_o,
    input wire logic       hub_high_supply_o,
    input wire logic       fan_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Counts how long the hub has sat on the high supply.
    logic [31:0] hi_cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !hub_high_supply_o) begin
            hi_cnt_q <= '0;
        end else begin
            hi_cnt_q <= hi_cnt_q + 32'h1;
        end
    end

    property p_lamp_on;  ring_flag_i [*4] |=> write_permit_lamp_o; endproperty
    property p_lamp_off; !ring_flag_i [*4] |=> !write_permit_lamp_o; endproperty
    property p_req;      unload_req_o |-> !rewind_req_o ##1 !unload_req_o; endproperty
    property p_hub_hi;   $rose(hub_solenoid_o) |-> ##[0:1] hub_high_supply_o; endproperty
    property p_hub_lim;  hi_cnt_q <= HIGH_DRIVE_CYC + 1; endproperty
    property p_fan_off;  !enter_btn_i [*4] |=> !fan_o; endproperty
    property p_door_off; !units_btn_i [*4] |=> !door_solenoid_o; endproperty
    property p_bot_ltr;  !bot_marker_i [*4] |=> !display_letters_o[2]; endproperty
    property p_arm_ltr;  arm_rest_flag_i [*4] |=> !display_letters_o[5]; endproperty
    property p_legend;
        (!arm_rest_flag_i && !arm_far_flag_i) [*4] |=> !limit_legend_o;
    endproperty
    property p_val_max;  display_value_o <= 10'h3e7; endproperty

    a_lamp_on:  assert property (p_lamp_on) else $error("lamp off with ring");
    a_lamp_off: assert property (p_lamp_off) else $error("lamp on no ring");
    a_req:      assert property (p_req) else $error("bad tape request");
    a_hub_hi:   assert property (p_hub_hi) else $error("no high drive");
    a_hub_lim:  assert property (p_hub_lim) else $error("high drive too long");
    a_fan_off:  assert property (p_fan_off) else $error("fan stuck on");
    a_door_off: assert property (p_door_off) else $error("door stuck on");
    a_bot_ltr:  assert property (p_bot_ltr) else $error("bad marker letter");
    a_arm_ltr:  assert property (p_arm_ltr) else $error("arm letter at rest");
    a_legend:   assert property (p_legend) else $error("legend mid travel");
    a_val_max:  assert property (p_val_max) else $error("value above 999");

    c_unload: cover property (unload_req_o);
    c_rewind: cover property (rewind_req_o);
    c_hold:   cover property ($fell(hub_high_supply_o) && hub_solenoid_o);
    c_legend: cover property ($rose(limit_legend_o));
endmodule : tpsd_properties

bind tpsd_top tpsd_properties #(
    .MS_CYCLES(MS_CYCLES), .HIGH_DRIVE_CYC(HIGH_DRIVE_CYC), .POS_W(POS_W)
) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .enter_btn_i(enter_btn_i), .units_btn_i(units_btn_i),
    .bot_marker_i(bot_marker_i), .ring_flag_i(ring_flag_i),
    .arm_rest_flag_i(arm_rest_flag_i), .arm_far_flag_i(arm_far_flag_i),
    .unload_req_o(unload_req_o), .rewind_req_o(rewind_req_o),
    .display_letters_o(display_letters_o), .display_value_o(display_value_o),
    .limit_legend_o(limit_legend_o), .write_permit_lamp_o(write_permit_lamp_o),
    .hub_solenoid_o(hub_solenoid_o), .door_solenoid_o(door_solenoid_o),
    .hub_high_supply_o(hub_high_supply_o), .fan_o(fan_o)
);

`default_nettype wire

/* test/tpsd_tape_model.sv */
// Tape motion model that answers unload and rewind requests.
// Assumes one-cycle request pulses on the shared clock.
`default_nettype none

module tpsd_tape_model #(
    parameter int DELAY = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic unload_req_i,
    input  wire logic rewind_req_i,
    output logic      tape_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 0;
        end else if (unload_req_i || rewind_req_i) begin
            cnt_q <= DELAY;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
        tape_done_o <= !rst_i && (cnt_q == 1);
    end
endmodule : tpsd_tape_model

`default_nettype wire

/* test/tpsd_top_tb.sv */
// Bench for tpsd_top: Wishbone calls and pin stimulus with expected values.
// Assumes short ms and high drive counts set by parameter.
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end

module tpsd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS  = 10;
    localparam int HDC = 50;
    logic        clk_i, rst_i, cyc, stb, we, tens, units, enter;
    logic        chute, reel, bot, eot, ring, rest, far, done, ack, irq, unl, rew;
    logic        legend, lamp, hub, door, hubh, doorh, fan;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, dat_o;
    logic [5:0]  letters;
    logic [9:0]  pos, value;
    int          error_cnt, num_checks;

    tpsd_top #(.MS_CYCLES(MS), .HIGH_DRIVE_CYC(HDC), .POS_W(10)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .irq_o(irq), .tens_btn_i(tens), .units_btn_i(units), .enter_btn_i(enter),
        .chute_clear_i(chute), .reel_flag_i(reel), .bot_marker_i(bot), .eot_marker_i(eot),
        .ring_flag_i(ring), .arm_rest_flag_i(rest), .arm_far_flag_i(far), .arm_pos_i(pos),
        .tape_done_i(done), .unload_req_o(unl), .rewind_req_o(rew),
        .display_letters_o(letters), .display_value_o(value), .limit_legend_o(legend),
        .write_permit_lamp_o(lamp), .hub_solenoid_o(hub), .door_solenoid_o(door),
        .hub_high_supply_o(hubh), .door_high_supply_o(doorh), .fan_o(fan));

    tpsd_tape_model #(.DELAY(8)) u_tape (.clk_i(clk_i), .rst_i(rst_i),
        .unload_req_i(unl), .rewind_req_i(rew), .tape_done_o(done));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wait_req(input logic want_unl);
        int n;
        n = 0;
        while ((want_unl ? unl : rew) !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n < 50, 1'b1)
    endtask : wait_req

    task automatic press_tens();
        tens <= 1'b1;
        tick(5);
        tens <= 1'b0;
        tick(5);
    endtask : press_tens

    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        tick(20000);
        error_cnt++;
        conclude();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_i, cyc, stb, we, tens, units, enter, chute, reel, eot, ring, far} = '0;
        {adr, wdat, pos} = '0;
        bot = 1'b1;
        rest = 1'b1;
        error_cnt = 0;
        num_checks = 0;
        rst_i = 1'b1;
        tick(6);
        rst_i <= 1'b0;
        wb(0, tpsd_pkg::OFS_CTRL, 0);
        `CHK(rdat, 32'h0)
        wb(0, 8'h40, 0);
        `CHK(rdat, 32'h0)
        wb(1, tpsd_pkg::OFS_CTRL, 1);
        wait_req(1);
        tick(12);
        wb(0, tpsd_pkg::OFS_IRQ_STAT, 0);
        `CHK(rdat, 32'h1)
        `CHK(irq, 1'b0)
        wb(1, tpsd_pkg::OFS_IRQ_EN, 1);
        `CHK(irq, 1'b1)
        wb(1, tpsd_pkg::OFS_IRQ_CLR, 1);
        `CHK(irq, 1'b0)
        for (int i = 0; i < 6; i++) begin
            {ring, eot, bot, reel, chute} <= 5'(1 << i);
            rest <= (i != 5);
            tick(5);
            `CHK(letters, 6'(1 << i))
            `CHK(lamp, (i == 4))
        end
        far <= 1'b1;
        tick(5);
        `CHK(letters, 6'h00)
        {far, rest} <= 2'b01;
        for (int b = 0; b < 3; b++) begin
            {enter, units, tens} <= 3'(1 << b);
            tick(5);
            `CHK({fan, door, hub}, 3'(1 << b))
            `CHK({doorh, hubh}, (b == 2) ? 2'b00 : 2'(1 << b))
            tick(HDC + 4);
            `CHK({doorh, hubh, fan, door, hub}, {2'b00, 3'(1 << b)})
            {enter, units, tens} <= 3'b000;
            tick(5);
            `CHK({fan, door, hub}, 3'b000)
        end
        tens <= 1'b1;
        tick(5);
        wb(1, tpsd_pkg::OFS_CTRL, 2);
        wait_req(0);
        `CHK(hub, 1'b0)
        tens <= 1'b0;
        tick(15);
        press_tens();
        ring <= 1'b1;
        tick(5);
        ring <= 1'b0;
        tick(3);
        press_tens();
        wb(0, tpsd_pkg::OFS_STATUS, 0);
        `CHK(rdat[5:0], 6'h36)
        wb(0, tpsd_pkg::OFS_IRQ_STAT, 0);
        `CHK(rdat[3:0], 4'h3)
        wb(1, tpsd_pkg::OFS_CTRL, 3);
        pos <= 10'h07b;
        tick(6);
        `CHK({legend, value}, {1'b1, 10'h07b})
        rest <= 1'b0;
        tick(6);
        `CHK(legend, 1'b0)
        pos <= 10'h0b4;
        far <= 1'b1;
        tick(6);
        `CHK({legend, value}, {1'b1, 10'h0b4})
        wb(1, tpsd_pkg::OFS_CTRL, 4);
        for (int k = 25; k > 0; k -= 13) begin
            {far, rest} <= 2'b10;
            tick(5);
            far <= 1'b0;
            tick(k * MS);
            rest <= 1'b1;
            tick(6);
            wb(0, tpsd_pkg::OFS_FLIGHT, 0);
            `CHK(rdat >= k - 1 && rdat <= k + 1, 1'b1)
            `CHK(value, rdat[9:0])
            wb(0, tpsd_pkg::OFS_STATUS, 0);
            `CHK(rdat[6], (k > 20))
        end
        conclude();
    end
endmodule : tpsd_top_tb

`default_nettype wire
